// ---- testbench/cdd_clk_rx.sv ----
`timescale 1ns/1ps

module cdd_clk_rx
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Received clock level
  input wire logic i_level,
  // Phase lengths in system cycles
  output logic [7:0] o_high_len,
  output logic [7:0] o_low_len,
  output logic [7:0] o_still
);
  logic last_q;

  // Saturates so a stopped clock reads as a long still time.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      last_q <= 1'b0;
      o_still <= 8'h00;
      o_high_len <= 8'h00;
      o_low_len <= 8'h00;
    end
    else if (i_level != last_q)
    begin
      last_q <= i_level;
      o_still <= 8'h00;
      if (last_q)
        o_high_len <= o_still + 8'h01;
      else
        o_low_len <= o_still + 8'h01;
    end
    else if (o_still != 8'hFF)
      o_still <= o_still + 8'h01;
  end
endmodule

// ---- testbench/tb_cdd_clock_distribution.sv ----
`timescale 1ns/1ps
`include "cdd_cfg.svh"

module tb_cdd_clock_distribution;
  logic clk;
  logic rst;
  logic psel;
  logic pen;
  logic pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  logic ext_e;
  logic osc_e;
  wire [5:0] lv;
  wire [7:0] hi [6];
  wire [7:0] lo [6];
  wire [7:0] st [6];
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  cdd_clock_distribution uut
  (
    .i_clk(clk),
    .i_rst(rst),
    .i_psel(psel),
    .i_penable(pen),
    .i_pwrite(pwr),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_ext_edge(ext_e),
    .i_osc_edge(osc_e),
    .o_first_pair_output_a(lv[0]),
    .o_first_pair_output_b(lv[1]),
    .o_second_pair_output_a(lv[2]),
    .o_second_pair_output_b(lv[3]),
    .o_third_pair_output(lv[4]),
    .o_fourth_pair_output(lv[5])
  );

  genvar g;
  for (g = 0; g < 6; g++)
  begin : rx
    cdd_clk_rx u_rx
    (
      .i_clk(clk),
      .i_rst(rst),
      .i_level(lv[g]),
      .o_high_len(hi[g]),
      .o_low_len(lo[g]),
      .o_still(st[g])
    );
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // External edges every cycle, oscillator edges every other cycle.
  always @(posedge clk)
    osc_e <= ~osc_e;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [8:0] i,
    input logic [7:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {1'b0, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask

  task automatic sync();
    wr(`CDD_IDX_SYNC, 8'h01);
  endtask

  task automatic settle();
    repeat (150) @(posedge clk);
  endtask

  task automatic ph(input int k, input logic [7:0] h, input logic [7:0] l);
    chk({24'h000000, hi[k]}, {24'h000000, h});
    chk({24'h000000, lo[k]}, {24'h000000, l});
  endtask

  // Counts from the sync until the first pair rises after the restart.
  // The old setting still reaches the pin for two edges, so those are
  // ignored; otherwise a rise of the old clock could end the count.
  task automatic rise(output int t);
    logic low;
    sync();
    t = 0;
    low = 1'b0;
    while (!(low && lv[0] === 1'b1) && t < 300)
    begin
      @(posedge clk);
      t++;
      if (t >= 3 && lv[0] === 1'b0)
        low = 1'b1;
    end
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, `CDD_IDX_PRE, 8'h00, r, e);
    chk(r, 32'h00000002);
    apb(1'b0, `CDD_IDX_SRC, 8'h00, r, e);
    chk(r, 32'h00000000);
    apb(1'b0, 9'h100, 8'h00, r, e);
    chk({r[30:0], e}, 32'h00000001);
    wr(`CDD_IDX_CH1_CNT, 8'hA5);
    apb(1'b0, `CDD_IDX_CH1_CNT, 8'h00, r, e);
    chk(r, 32'h000000A5);
    $display("t_regs done");
  endtask

  task automatic t_div();
    wr(`CDD_IDX_SRC, 8'h01);
    wr(`CDD_IDX_CH0_CNT, 8'h31);
    wr(`CDD_IDX_CH0_RTE, 8'h01);
    wr(`CDD_IDX_CH1_CNT, 8'h00);
    wr(`CDD_IDX_CH1_RTE, 8'h01);
    sync();
    settle();
    ph(0, 8'h04, 8'h08);
    ph(1, 8'h04, 8'h08);
    ph(2, 8'h02, 8'h02);
    wr(`CDD_IDX_CH0_CNT, 8'h00);
    settle();
    ph(0, 8'h04, 8'h08);
    sync();
    settle();
    ph(0, 8'h02, 8'h02);
    $display("t_div done");
  endtask

  task automatic t_pre();
    int r;
    logic [31:0] d;
    logic e;
    wr(`CDD_IDX_SRC, 8'h00);
    for (r = 2; r <= 6; r++)
    begin
      wr(`CDD_IDX_PRE, r[7:0]);
      sync();
      settle();
      ph(0, 8'(2 * r), 8'(2 * r));
    end
    wr(`CDD_IDX_PRE, 8'h03);
    wr(`CDD_IDX_SRC, 8'h02);
    sync();
    settle();
    ph(0, 8'h0C, 8'h0C);
    wr(`CDD_IDX_SRC, 8'h01);
    sync();
    settle();
    ph(0, 8'h02, 8'h02);
    wr(`CDD_IDX_SRC, 8'h03);
    sync();
    settle();
    chk({31'h0, st[0] >= 8'h64}, 32'h00000001);
    apb(1'b0, `CDD_IDX_STAT, 8'h00, d, e);
    chk(d, 32'h00000001);
    $display("t_pre done");
  endtask

  task automatic t_byp();
    wr(`CDD_IDX_SRC, 8'h01);
    wr(`CDD_IDX_CH0_BYP, 8'h80);
    sync();
    settle();
    ph(0, 8'h01, 8'h01);
    wr(`CDD_IDX_CH0_BYP, 8'h00);
    $display("t_byp done");
  endtask

  task automatic t_dir();
    wr(`CDD_IDX_SRC, 8'h00);
    wr(`CDD_IDX_PRE, 8'h04);
    wr(`CDD_IDX_CH1_RTE, 8'h03);
    sync();
    settle();
    ph(2, 8'h01, 8'h01);
    ph(3, 8'h01, 8'h01);
    ph(0, 8'h08, 8'h08);
    wr(`CDD_IDX_CH0_RTE, 8'h03);
    wr(`CDD_IDX_CH1_RTE, 8'h01);
    sync();
    settle();
    ph(0, 8'h01, 8'h01);
    ph(2, 8'h08, 8'h08);
    wr(`CDD_IDX_CH0_RTE, 8'h01);
    $display("t_dir done");
  endtask

  task automatic t_dcc();
    wr(`CDD_IDX_SRC, 8'h01);
    wr(`CDD_IDX_CH0_CNT, 8'h21);
    wr(`CDD_IDX_CH0_RTE, 8'h00);
    sync();
    settle();
    ph(0, 8'h05, 8'h05);
    wr(`CDD_IDX_CH0_RTE, 8'h01);
    sync();
    settle();
    ph(0, 8'h04, 8'h06);
    $display("t_dcc done");
  endtask

  task automatic t_dly();
    int a;
    int b;
    wr(`CDD_IDX_CH0_CNT, 8'h00);
    wr(`CDD_IDX_CH0_BYP, 8'h01);
    rise(a);
    wr(`CDD_IDX_CH0_BYP, 8'h06);
    rise(b);
    chk(32'(b - a), 32'h0000000A);
    wr(`CDD_IDX_CH0_CNT, 8'h30);
    wr(`CDD_IDX_CH0_BYP, 8'h01);
    rise(a);
    wr(`CDD_IDX_CH0_BYP, 8'h13);
    rise(b);
    chk(32'(b - a), 32'h0000000C);
    wr(`CDD_IDX_CH0_BYP, 8'h00);
    $display("t_dly done");
  endtask

  task automatic t_casc();
    wr(`CDD_IDX_G2_BASE, 8'h00);
    wr(`CDD_IDX_G2_BASE + 9'h001, 8'h20);
    wr(`CDD_IDX_G2_BASE + 9'h002, 8'h10);
    wr(`CDD_IDX_G2_BASE + 9'h003, 8'h20);
    wr(`CDD_IDX_G2_BASE + 9'h005, 8'h80);
    wr(`CDD_IDX_G2_LAST, 8'h80);
    sync();
    settle();
    ph(4, 8'h04, 8'h08);
    ph(5, 8'h01, 8'h01);
    $display("t_casc done");
  endtask

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ext_e = 1'b1;
    osc_e = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_div();
    t_pre();
    t_byp();
    t_dir();
    t_dcc();
    t_dly();
    t_casc();
    finish_test();
  end
endmodule

// ---- verilog/cdd_cfg.svh ----
`ifndef CDD_CFG_SVH
`define CDD_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define CDD_IDX_CH0_CNT 9'h190
`define CDD_IDX_CH0_BYP 9'h191
`define CDD_IDX_CH0_RTE 9'h192
`define CDD_IDX_CH1_CNT 9'h196
`define CDD_IDX_CH1_BYP 9'h197
`define CDD_IDX_CH1_RTE 9'h198
`define CDD_IDX_G2_BASE 9'h199
`define CDD_IDX_G2_LAST 9'h1A0
`define CDD_IDX_PRE 9'h1E0
`define CDD_IDX_SRC 9'h1E1
`define CDD_IDX_SYNC 9'h1E2
`define CDD_IDX_STAT 9'h1E3

// Storage slots of the register array.
`define CDD_SLOT_CH0_CNT 4'h0
`define CDD_SLOT_CH0_BYP 4'h1
`define CDD_SLOT_CH0_RTE 4'h2
`define CDD_SLOT_CH1_CNT 4'h3
`define CDD_SLOT_CH1_BYP 4'h4
`define CDD_SLOT_CH1_RTE 4'h5
`define CDD_SLOT_G2 9'h006
`define CDD_SLOT_PRE 4'hE
`define CDD_SLOT_SRC 4'hF

// Field positions.
`define CDD_BIT_BYPASS 7
`define CDD_BIT_DUTY_OFF_G2 5
`define CDD_BIT_BEGIN_HIGH 4
`define CDD_BIT_DIRECT 1
`define CDD_BIT_DUTY_OFF 0
`define CDD_BIT_SYNC 0

// Reset values and limits.
`define CDD_RST_PRE 8'h02
`define CDD_RST_SRC 8'h00
`define CDD_PRE_MIN 3'h2
`define CDD_PRE_MAX 3'h6
`define CDD_PADDR_W 12

`endif

// ---- verilog/cdd_chan_div.sv ----
`timescale 1ns/1ps
`include "cdd_cfg.svh"

module cdd_chan_div
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Input clock edge events and restart strobe
  input wire logic i_edge,
  input wire logic i_load,
  // Settings, sampled on i_load
  input wire logic i_bypass,
  input wire logic i_duty_fix_disable,
  input wire logic i_begin_level_high,
  input wire logic [3:0] i_delay,
  input wire logic [3:0] i_low_cnt,
  input wire logic [3:0] i_high_cnt,
  // Divided clock and its edge events
  output logic o_level,
  output logic o_edge
);

  typedef struct packed {
    cdd_pkg::cdd_div_state_t st;
    logic [6:0] cnt;
    logic [6:0] hi_len;
    logic [6:0] lo_len;
    logic level;
    logic pulse;
  } cdd_div_t;

  cdd_div_t s_q;
  cdd_div_t s_d;
  logic [5:0] dly;
  logic odd_fix;
  logic [6:0] ev_q;
  logic [6:0] dly_ev_q;

  // Counting half cycles lets an odd ratio be split into equal halves.
  function automatic logic [6:0] halves(input logic [5:0] cycles);
    halves = {cycles, 1'b0};
  endfunction

  assign odd_fix = !i_duty_fix_disable &&
    ({2'h0, i_low_cnt} == {2'h0, i_high_cnt} + 6'h01);
  assign dly = i_begin_level_high ?
    {2'h0, i_delay} + {2'h0, i_low_cnt} + 6'h01 : {2'h0, i_delay};

  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (i_load)
    begin
      s_d.level = 1'b0;
      s_d.cnt = i_bypass ? 7'h00 : halves(dly);
      s_d.hi_len = odd_fix ? {2'h0, i_high_cnt, 1'b0} + 7'h03 :
        halves({2'h0, i_high_cnt} + 6'h01);
      s_d.lo_len = odd_fix ? {2'h0, i_high_cnt, 1'b0} + 7'h03 :
        halves({2'h0, i_low_cnt} + 6'h01);
      s_d.st = i_bypass ? cdd_pkg::ST_BYPASS : cdd_pkg::ST_DELAY;
    end
    else if (i_edge)
    begin
      case (s_q.st)
        cdd_pkg::ST_BYPASS:
        begin
          s_d.level = !s_q.level;
          s_d.pulse = 1'b1;
        end
        cdd_pkg::ST_DELAY, cdd_pkg::ST_LOW:
        begin
          if (s_q.cnt == 7'h00)
          begin
            s_d.level = 1'b1;
            s_d.pulse = 1'b1;
            s_d.st = cdd_pkg::ST_HIGH;
            s_d.cnt = s_q.hi_len - 7'h01;
          end
          else
            s_d.cnt = s_q.cnt - 7'h01;
        end
        cdd_pkg::ST_HIGH:
        begin
          if (s_q.cnt == 7'h00)
          begin
            s_d.level = 1'b0;
            s_d.pulse = 1'b1;
            s_d.st = cdd_pkg::ST_LOW;
            s_d.cnt = s_q.lo_len - 7'h01;
          end
          else
            s_d.cnt = s_q.cnt - 7'h01;
        end
        default:
          s_d.pulse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '0;
      s_q.st <= cdd_pkg::ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign o_level = s_q.level;
  assign o_edge = s_q.pulse;

  // Helper counters for the checks below.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ev_q <= 7'h00;
      dly_ev_q <= 7'h00;
    end
    else
    begin
      if (i_load || s_d.pulse)
        ev_q <= 7'h00;
      else if (i_edge)
        ev_q <= ev_q + 7'h01;
      if (i_load)
        dly_ev_q <= halves(dly);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_high_len;
    s_q.st == cdd_pkg::ST_HIGH && s_d.st == cdd_pkg::ST_LOW |->
      ev_q + 7'h01 == s_q.hi_len;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("high phase length differs from programmed count");

  property p_low_len;
    s_q.st == cdd_pkg::ST_LOW && s_d.st == cdd_pkg::ST_HIGH |->
      ev_q + 7'h01 == s_q.lo_len;
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("low phase length differs from programmed count");

  property p_delay;
    s_q.st == cdd_pkg::ST_DELAY && s_d.st == cdd_pkg::ST_HIGH |->
      ev_q == dly_ev_q;
  endproperty
  a_delay: assert property (p_delay)
    else $error("first rising edge not delayed by the delay code");

  property p_bypass;
    s_q.st == cdd_pkg::ST_BYPASS && i_edge && !i_load |=>
      o_edge && o_level != $past(o_level);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed divider did not follow its input");

  property p_odd_balance;
    i_load && !i_bypass && !i_duty_fix_disable && i_high_cnt != 4'hF &&
      i_low_cnt == i_high_cnt + 4'h1 |=>
      s_q.hi_len == s_q.lo_len ##1 s_q.hi_len[0];
  endproperty
  a_odd_balance: assert property (p_odd_balance)
    else $error("odd ratio not balanced with correction enabled");

  c_odd_fix: cover property (s_q.st == cdd_pkg::ST_HIGH && s_q.hi_len[0]);

endmodule

// ---- verilog/cdd_clock_distribution.sv ----
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "cdd_cfg.svh"

module cdd_clock_distribution
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB register slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`CDD_PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Source clock edge events, one pulse per rising or falling edge
  input wire logic i_ext_edge,
  input wire logic i_osc_edge,
  // Distributed clocks
  output logic o_first_pair_output_a,
  output logic o_first_pair_output_b,
  output logic o_second_pair_output_a,
  output logic o_second_pair_output_b,
  output logic o_third_pair_output,
  output logic o_fourth_pair_output
);

  typedef struct packed {
    logic [15:0][7:0] regs;
    logic [15:0][7:0] act;
    logic apply;
    logic [2:0] pre_cnt;
    logic pre_edge;
    logic direct_lvl;
    logic [3:0] outs;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cdd_top_t;

  cdd_top_t s_q;
  cdd_top_t s_d;
  cdd_pkg::cdd_source_t src;
  logic src_edge;
  logic pre_used;
  logic chan_in;
  logic restart;
  logic setup;
  logic access;
  logic adr_ok;
  logic [8:0] idx;
  logic [4:0] dec;
  logic is_sync;
  logic is_stat;
  logic sync_wr;
  logic [2:0] ratio;
  logic [5:0] div_lvl;
  logic [5:0] div_edge;
  logic [2:0] hpe_q;

  // Storage slot of a register index; bit 4 marks a hit.
  function automatic logic [4:0] slot_of(input logic [8:0] i);
    case (i)
      `CDD_IDX_CH0_CNT: slot_of = {1'b1, `CDD_SLOT_CH0_CNT};
      `CDD_IDX_CH0_BYP: slot_of = {1'b1, `CDD_SLOT_CH0_BYP};
      `CDD_IDX_CH0_RTE: slot_of = {1'b1, `CDD_SLOT_CH0_RTE};
      `CDD_IDX_CH1_CNT: slot_of = {1'b1, `CDD_SLOT_CH1_CNT};
      `CDD_IDX_CH1_BYP: slot_of = {1'b1, `CDD_SLOT_CH1_BYP};
      `CDD_IDX_CH1_RTE: slot_of = {1'b1, `CDD_SLOT_CH1_RTE};
      `CDD_IDX_PRE: slot_of = {1'b1, `CDD_SLOT_PRE};
      `CDD_IDX_SRC: slot_of = {1'b1, `CDD_SLOT_SRC};
      default:
        slot_of = (i >= `CDD_IDX_G2_BASE && i <= `CDD_IDX_G2_LAST) ?
          {1'b1, 4'(i - `CDD_IDX_G2_BASE + `CDD_SLOT_G2)} : 5'h00;
    endcase
  endfunction

  // Out-of-range values of bits 2:0 are clamped rather than stopping the clock; higher bits are ignored.
  function automatic logic [2:0] pre_ratio(input logic [7:0] r);
    if (r[2:0] < `CDD_PRE_MIN)
      pre_ratio = `CDD_PRE_MIN;
    else if (r[2:0] > `CDD_PRE_MAX)
      pre_ratio = `CDD_PRE_MAX;
    else
      pre_ratio = r[2:0];
  endfunction

  // Code 11 passes no edges, so every output stops rather than glitching.
  assign src = cdd_pkg::cdd_source_t'(s_q.act[`CDD_SLOT_SRC][1:0]);
  assign src_edge = (src == cdd_pkg::SRC_EXT_PRE ||
    src == cdd_pkg::SRC_EXT_DIRECT) ? i_ext_edge :
    (src == cdd_pkg::SRC_OSC_PRE) ? i_osc_edge : 1'b0;
  assign pre_used = src == cdd_pkg::SRC_EXT_PRE ||
    src == cdd_pkg::SRC_OSC_PRE;
  assign chan_in = pre_used ? s_q.pre_edge : src_edge;
  assign ratio = pre_ratio(s_q.act[`CDD_SLOT_PRE]);

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && s_q.pready;
  assign adr_ok = !i_paddr[11] && i_paddr[1:0] == 2'h0;
  assign idx = i_paddr[10:2];
  assign dec = adr_ok ? slot_of(idx) : 5'h00;
  assign is_sync = adr_ok && idx == `CDD_IDX_SYNC;
  assign is_stat = adr_ok && idx == `CDD_IDX_STAT;
  assign sync_wr = access && i_pwrite && is_sync &&
    i_pwdata[`CDD_BIT_SYNC];
  assign restart = sync_wr || s_q.apply;

  always_comb
  begin
    s_d = s_q;
    s_d.apply = 1'b0;
    s_d.pre_edge = 1'b0;
    s_d.pready = setup;
    if (setup)
    begin
      s_d.pslverr = !(dec[4] || is_sync || is_stat);
      if (dec[4])
        s_d.prdata = {24'h000000, s_q.regs[dec[3:0]]};
      else if (is_stat)
        s_d.prdata = {26'h0000000, s_q.outs, pre_used,
          src == cdd_pkg::SRC_INVALID};
      else
        s_d.prdata = 32'h00000000;
    end
    if (access && i_pwrite && dec[4])
      s_d.regs[dec[3:0]] = i_pwdata[7:0];
    // Settings are copied only here, so counters never see a half update.
    if (sync_wr)
    begin
      s_d.act = s_q.regs;
      s_d.apply = 1'b1;
    end
    if (restart)
      s_d.pre_cnt = 3'h0;
    else if (src_edge)
    begin
      if (s_q.pre_cnt == ratio - 3'h1)
      begin
        s_d.pre_cnt = 3'h0;
        s_d.pre_edge = pre_used;
      end
      else
        s_d.pre_cnt = s_q.pre_cnt + 3'h1;
    end
    if (restart)
      s_d.direct_lvl = 1'b0;
    else if (src_edge)
      s_d.direct_lvl = !s_q.direct_lvl;
    s_d.outs[0] = s_q.act[`CDD_SLOT_CH0_RTE][`CDD_BIT_DIRECT] ?
      s_q.direct_lvl : div_lvl[0];
    s_d.outs[1] = s_q.act[`CDD_SLOT_CH1_RTE][`CDD_BIT_DIRECT] ?
      s_q.direct_lvl : div_lvl[1];
    s_d.outs[2] = div_lvl[3];
    s_d.outs[3] = div_lvl[5];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '0;
      s_q.regs[`CDD_SLOT_PRE] <= `CDD_RST_PRE;
      s_q.regs[`CDD_SLOT_SRC] <= `CDD_RST_SRC;
      s_q.act[`CDD_SLOT_PRE] <= `CDD_RST_PRE;
      s_q.act[`CDD_SLOT_SRC] <= `CDD_RST_SRC;
      s_q.apply <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Dividers 0 and 1 feed pairs one and two; 2 to 5 form two cascades.
  for (genvar k = 0; k < 6; k++)
  begin : g_div
    localparam int C = (k < 2) ? 3 * k : 2 * k + 2;
    logic edge_in;
    logic fix_off;
    if (k == 3 || k == 5)
    begin : g_casc
      assign edge_in = div_edge[k - 1];
      assign fix_off = s_q.act[C + 1][`CDD_BIT_DUTY_OFF_G2];
    end
    else if (k >= 2)
    begin : g_first
      assign edge_in = chan_in;
      assign fix_off = s_q.act[C + 1][`CDD_BIT_DUTY_OFF_G2];
    end
    else
    begin : g_single
      assign edge_in = chan_in;
      assign fix_off = s_q.act[C + 2][`CDD_BIT_DUTY_OFF];
    end
    cdd_chan_div u_div
    (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_edge(edge_in),
      .i_load(s_q.apply),
      .i_bypass(s_q.act[C + 1][`CDD_BIT_BYPASS]),
      .i_duty_fix_disable(fix_off),
      .i_begin_level_high(s_q.act[C + 1][`CDD_BIT_BEGIN_HIGH]),
      .i_delay(s_q.act[C + 1][3:0]),
      .i_low_cnt(s_q.act[C][7:4]),
      .i_high_cnt(s_q.act[C][3:0]),
      .o_level(div_lvl[k]),
      .o_edge(div_edge[k])
    );
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_first_pair_output_a = s_q.outs[0];
  assign o_first_pair_output_b = s_q.outs[0];
  assign o_second_pair_output_a = s_q.outs[1];
  assign o_second_pair_output_b = s_q.outs[1];
  assign o_third_pair_output = s_q.outs[2];
  assign o_fourth_pair_output = s_q.outs[3];

  // Source edges seen since the last prescaler output edge.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      hpe_q <= 3'h0;
    else if (s_q.pre_edge)
      hpe_q <= (src_edge && !restart) ? 3'h1 : 3'h0;
    else if (restart)
      hpe_q <= 3'h0;
    else if (src_edge && pre_used)
      hpe_q <= hpe_q + 3'h1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_apb_ready;
    setup |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB ready not a single cycle after setup");

  property p_hold_until_sync;
    !sync_wr |=> $stable(s_q.act);
  endproperty
  a_hold_until_sync: assert property (p_hold_until_sync)
    else $error("active settings changed without a sync");

  property p_invalid_quiet;
    src == cdd_pkg::SRC_INVALID && !restart |=>
      !s_q.pre_edge && $stable(s_q.direct_lvl);
  endproperty
  a_invalid_quiet: assert property (p_invalid_quiet)
    else $error("invalid source code still passes edges");

  property p_pre_period;
    s_q.pre_edge |-> hpe_q == ratio;
  endproperty
  a_pre_period: assert property (p_pre_period)
    else $error("prescaler period differs from programmed ratio");

  property p_direct;
    s_q.act[`CDD_SLOT_CH0_RTE][`CDD_BIT_DIRECT] && src_edge && !restart
      |=> ##1 o_first_pair_output_a != $past(o_first_pair_output_a);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct route did not follow the source edge");

  // An unmapped word must answer at once, with an error and zero data.
  property p_refused;
    setup && !(dec[4] || is_sync || is_stat) |=>
      o_pready && o_pslverr && o_prdata == 32'h00000000;
  endproperty
  a_refused: assert property (p_refused)
    else $error("unmapped access was not refused");

  c_sync: cover property (sync_wr);
  c_invalid: cover property (src == cdd_pkg::SRC_INVALID && !restart);
  c_direct: cover property (s_q.act[`CDD_SLOT_CH0_RTE][`CDD_BIT_DIRECT]
    && src_edge ##2 o_first_pair_output_a);

endmodule

// ---- verilog/cdd_pkg.sv ----
package cdd_pkg;

  typedef enum logic [1:0] {
    SRC_EXT_PRE = 2'h0,
    SRC_EXT_DIRECT = 2'h1,
    SRC_OSC_PRE = 2'h2,
    SRC_INVALID = 2'h3
  } cdd_source_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_HIGH = 5'h04,
    ST_LOW = 5'h08,
    ST_BYPASS = 5'h10
  } cdd_div_state_t;

endpackage
